// ### core/link_pkg.sv
/*
 * Shared constants, symbol kinds and the scrambler step for the link
 * transmit scheduler and its partner receiver.
 * Assumes one symbol per clock at 40 MHz and a byte-wide symbol stream.
 */
package link_pkg;

   typedef enum logic [2:0] {
      K_IDLE = 3'h0,
      K_HP = 3'h1,
      K_DPH = 3'h2,
      K_DPP = 3'h3,
      K_LC = 3'h4,
      K_SKP = 3'h5
   } sym_kind_t;

   localparam logic [7:0] IDLE_BASE = 8'h00;
   localparam logic [7:0] IDLE_ENH = 8'h5a;
   localparam logic [7:0] SKP_SYM = 8'h3c;
   localparam int CLK_PERIOD_NS = 25;
   localparam int PRES_TIME_NS = 10000;
   localparam int PRES_CYCLES = PRES_TIME_NS / CLK_PERIOD_NS;
   localparam int LC_LEN = 2;
   localparam int LC_W = 8 * LC_LEN;
   localparam int SKP_LEN = 4;
   localparam int BLK_LEN = 16;
   localparam int FIFO_DEPTH = 8;
   localparam int PKT_W = 12;
   // Presence command codes; values are arbitrary.
   localparam logic [15:0] LC_CODE_DN = 16'h0a01;
   localparam logic [15:0] LC_CODE_UP = 16'h0a02;
   localparam logic [15:0] SCR_SEED = 16'hffff;
   localparam logic [15:0] SCR_TAPS = 16'h0039;

   // Advances the scrambler by one byte time.
   function automatic logic [15:0] scr_next(input logic [15:0] s);
      logic [15:0] v;
      v = s;
      for (int i = 0; i < 8; i++) begin
         if (v[15]) begin
            v = {v[14:0], 1'b0} ^ SCR_TAPS;
         end else begin
            v = {v[14:0], 1'b0};
         end
      end
      return v;
   endfunction

   // Returns the byte to combine with one data symbol.
   function automatic logic [7:0] scr_byte(input logic [15:0] s);
      return s[15:8];
   endfunction

endpackage

// ### core/link_if.sv
/*
 * Symbol link between the transmit scheduler and the partner port.
 * Assumes both ends share clk_i; the bench joins the modports.
 */
`timescale 1ns/1ps
interface link_if;
   logic [7:0] sym;
   link_pkg::sym_kind_t kind;
   logic last;
   logic blk_start;
   logic blk_os;

   modport tx (output sym, output kind, output last, output blk_start, output blk_os);
   modport rx (input sym, input kind, input last, input blk_start, input blk_os);
endinterface

// ### core/sym_fifo.sv
/*
 * Synchronous FIFO with valid and ready on both sides.
 * Assumes a single clock and a synchronous active-low reset.
 */
`timescale 1ns/1ps
module sym_fifo #(
   parameter int WIDTH = link_pkg::PKT_W,
   parameter int DEPTH = link_pkg::FIFO_DEPTH
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_reg;
   logic [AW:0] rd_reg;
   logic [AW:0] cnt_reg;
   logic [AW:0] cnt_next;
   logic ready_reg;
   logic push;
   logic pop;

   assign push = in_valid_i && ready_reg;
   assign pop = out_valid_o && out_ready_i;
   assign in_ready_o = ready_reg;
   assign out_valid_o = (cnt_reg != '0);
   assign out_data_o = mem[rd_reg[AW-1:0]];

   always_comb begin
      cnt_next = cnt_reg;
      if (push && !pop) begin
         cnt_next = cnt_reg + 1'b1;
      end else if (pop && !push) begin
         cnt_next = cnt_reg - 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
         ready_reg <= 1'b0;
      end else begin
         wr_reg <= push ? wr_reg + 1'b1 : wr_reg;
         rd_reg <= pop ? rd_reg + 1'b1 : rd_reg;
         cnt_reg <= cnt_next;
         ready_reg <= (cnt_next != (AW+1)'(DEPTH));
      end
   end

   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wr_reg[AW-1:0]] <= in_data_i;
      end
   end
endmodule

// ### core/link_rx_port.sv
/*
 * Partner end: descrambles the symbol stream, passes packet bytes on,
 * reassembles link commands and flags misplaced ones.
 * Assumes the link is driven from the same clock.
 */
`timescale 1ns/1ps
module link_rx_port (
   input wire logic clk_i,
   input wire logic resetn_i,
   link_if.rx lnk,
   input wire logic scr_bypass_i,
   input wire logic enhanced_i,
   output logic rx_valid_o,
   output logic [7:0] rx_byte_o,
   output link_pkg::sym_kind_t rx_kind_o,
   output logic lc_valid_o,
   output logic [link_pkg::LC_W-1:0] lc_code_o,
   output logic place_err_o
);
   logic [15:0] lfsr_reg;
   logic in_pkt_reg;
   logic dph_done_reg;
   logic os_blk_reg;
   logic [7:0] lc_cnt_reg;
   logic [link_pkg::LC_W-1:0] lc_sh_reg;
   logic [7:0] plain;
   logic is_pkt;
   logic is_lc;
   logic os_now;
   logic bad;

   assign is_pkt = (lnk.kind == link_pkg::K_HP) || (lnk.kind == link_pkg::K_DPH)
                   || (lnk.kind == link_pkg::K_DPP);
   assign is_lc = (lnk.kind == link_pkg::K_LC);
   assign os_now = enhanced_i && (lnk.blk_start ? lnk.blk_os : os_blk_reg);
   assign plain = (lnk.kind == link_pkg::K_SKP || scr_bypass_i) ? lnk.sym
                  : lnk.sym ^ link_pkg::scr_byte(lfsr_reg);

   always_comb begin
      bad = 1'b0;
      if (is_lc && (in_pkt_reg || dph_done_reg)) begin
         bad = 1'b1;
      end
      if (is_lc && os_now) begin
         bad = 1'b1;
      end
      if (lnk.kind == link_pkg::K_IDLE &&
          plain != (enhanced_i ? link_pkg::IDLE_ENH : link_pkg::IDLE_BASE)) begin
         bad = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         lfsr_reg <= link_pkg::SCR_SEED;
         os_blk_reg <= 1'b0;
      end else begin
         if (lnk.kind != link_pkg::K_SKP) begin
            lfsr_reg <= link_pkg::scr_next(lfsr_reg);
         end
         if (lnk.blk_start) begin
            os_blk_reg <= lnk.blk_os;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         in_pkt_reg <= 1'b0;
         dph_done_reg <= 1'b0;
      end else if (is_pkt) begin
         in_pkt_reg <= !lnk.last;
         dph_done_reg <= lnk.last && (lnk.kind == link_pkg::K_DPH);
      end else if (is_lc) begin
         dph_done_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         lc_cnt_reg <= '0;
         lc_sh_reg <= '0;
         lc_valid_o <= 1'b0;
         lc_code_o <= '0;
      end else begin
         lc_valid_o <= 1'b0;
         if (is_lc) begin
            lc_sh_reg <= {lc_sh_reg[link_pkg::LC_W-9:0], plain};
            if (lc_cnt_reg == 8'(link_pkg::LC_LEN - 1)) begin
               lc_cnt_reg <= '0;
               lc_valid_o <= 1'b1;
               lc_code_o <= {lc_sh_reg[link_pkg::LC_W-9:0], plain};
            end else begin
               lc_cnt_reg <= lc_cnt_reg + 8'h01;
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         rx_valid_o <= 1'b0;
         rx_byte_o <= '0;
         rx_kind_o <= link_pkg::K_IDLE;
         place_err_o <= 1'b0;
      end else begin
         rx_valid_o <= is_pkt;
         rx_byte_o <= plain;
         rx_kind_o <= lnk.kind;
         place_err_o <= bad;
      end
   end
endmodule

// ### core/link_tx_port.sv
/*
 * Documented port end: schedules packets, link commands, skip sets and
 * idle symbols onto the symbol link, one symbol per clock.
 * Assumes the user streams packet bytes through the built-in FIFO without
 * gaps once a packet has begun, and that the partner samples on this clock.
 */
`timescale 1ns/1ps
module link_tx_port #(
   parameter int FIFO_DEPTH = link_pkg::FIFO_DEPTH,
   parameter int BLK_LEN = link_pkg::BLK_LEN,
   parameter int SKP_LEN = link_pkg::SKP_LEN
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   link_if.tx lnk,
   input wire logic u0_i,
   input wire logic downstream_i,
   input wire logic enhanced_i,
   input wire logic scr_bypass_i,
   input wire logic pkt_valid_i,
   output logic pkt_ready_o,
   input wire logic [7:0] pkt_data_i,
   input wire link_pkg::sym_kind_t pkt_kind_i,
   input wire logic pkt_last_i,
   input wire logic lc_valid_i,
   output logic lc_ready_o,
   input wire logic [link_pkg::LC_W-1:0] lc_code_i,
   input wire logic skp_req_i,
   output logic presence_sent_o
);
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_PKT = 2'b01,
      ST_LC = 2'b10,
      ST_SKP = 2'b11
   } tx_state_t;

   localparam logic [8:0] PRES_LAST = 9'(link_pkg::PRES_CYCLES - 1);
   localparam logic [7:0] LC_END = 8'(link_pkg::LC_LEN - 1);

   tx_state_t state_reg;
   tx_state_t state_next;
   logic [7:0] cnt_reg;
   logic [7:0] cnt_next;
   logic [7:0] blk_reg;
   logic [8:0] pres_reg;
   logic [15:0] lfsr_reg;
   logic lc_pend_reg;
   logic [link_pkg::LC_W-1:0] lc_pend_code_reg;
   logic [link_pkg::LC_W-1:0] lc_cur_reg;
   logic [link_pkg::LC_W-1:0] lc_cur_next;
   logic skp_pend_reg;
   logic lc_ready_reg;
   logic os_now;
   logic [7:0] sym_reg;
   link_pkg::sym_kind_t kind_reg;
   logic last_reg;
   logic blk_start_reg;
   logic blk_os_reg;
   logic os_cur_reg;

   logic f_valid;
   logic f_pop;
   logic [link_pkg::PKT_W-1:0] f_data;
   link_pkg::sym_kind_t f_kind;
   logic f_last;
   link_pkg::sym_kind_t e_kind;
   logic [7:0] e_raw;
   logic e_last;
   logic lc_take;
   logic skp_take;
   logic pres_take;
   logic blk_zero;
   logic skp_ok;
   logic [7:0] skp_end;
   logic [7:0] idle_sym;

   sym_fifo #(
      .WIDTH(link_pkg::PKT_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .in_valid_i(pkt_valid_i),
      .in_ready_o(pkt_ready_o),
      .in_data_i({pkt_last_i, pkt_kind_i, pkt_data_i}),
      .out_valid_o(f_valid),
      .out_ready_i(f_pop),
      .out_data_o(f_data)
   );

   assign f_kind = link_pkg::sym_kind_t'(f_data[10:8]);
   assign f_last = f_data[11];
   assign blk_zero = !enhanced_i || (blk_reg == '0);
   // skip sets open a whole ordered-set block
   assign skp_ok = skp_pend_reg && blk_zero;
   assign skp_end = enhanced_i ? 8'(BLK_LEN - 1) : 8'(SKP_LEN - 1);
   assign idle_sym = enhanced_i ? link_pkg::IDLE_ENH : link_pkg::IDLE_BASE;

   always_comb begin
      state_next = state_reg;
      cnt_next = '0;
      lc_cur_next = lc_cur_reg;
      e_kind = link_pkg::K_IDLE;
      e_raw = idle_sym;
      e_last = 1'b0;
      f_pop = 1'b0;
      lc_take = 1'b0;
      skp_take = 1'b0;
      pres_take = 1'b0;
      case (state_reg)
         ST_IDLE: begin
            if (!u0_i) begin
               e_kind = link_pkg::K_IDLE;
            end else if (skp_pend_reg) begin
               if (skp_ok) begin
                  skp_take = 1'b1;
                  e_kind = link_pkg::K_SKP;
                  e_raw = link_pkg::SKP_SYM;
                  state_next = (skp_end == '0) ? ST_IDLE : ST_SKP;
                  e_last = (skp_end == '0);
                  cnt_next = 8'h01;
               end
            end else if (lc_pend_reg) begin
               lc_take = 1'b1;
               lc_cur_next = lc_pend_code_reg;
               state_next = ST_LC;
            end else if (f_valid) begin
               state_next = ST_PKT;
            end else if (pres_reg == PRES_LAST) begin
               pres_take = 1'b1;
               lc_cur_next = downstream_i ? link_pkg::LC_CODE_DN : link_pkg::LC_CODE_UP;
               state_next = ST_LC;
            end
         end
         ST_PKT: begin
            if (f_valid) begin
               f_pop = 1'b1;
               e_kind = f_kind;
               e_raw = f_data[7:0];
               e_last = f_last;
               if (f_last) begin
                  state_next = (f_kind == link_pkg::K_DPH) ? ST_PKT : ST_IDLE;
               end
            end
         end
         ST_LC: begin
            e_kind = link_pkg::K_LC;
            e_raw = 8'(lc_cur_reg >> (link_pkg::LC_W - 8 - 8 * int'(cnt_reg)));
            cnt_next = cnt_reg + 8'h01;
            if (cnt_reg == LC_END) begin
               e_last = 1'b1;
               cnt_next = '0;
               state_next = ST_IDLE;
               if (lc_pend_reg && !skp_pend_reg) begin
                  lc_take = 1'b1;
                  lc_cur_next = lc_pend_code_reg;
                  state_next = ST_LC;
               end
            end
         end
         ST_SKP: begin
            e_kind = link_pkg::K_SKP;
            e_raw = link_pkg::SKP_SYM;
            cnt_next = cnt_reg + 8'h01;
            if (cnt_reg == skp_end) begin
               e_last = 1'b1;
               state_next = ST_IDLE;
               cnt_next = '0;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   assign os_now = enhanced_i && (skp_take || ((blk_reg != '0) && os_cur_reg));
   assign lc_ready_o = lc_ready_reg;
   assign lnk.sym = sym_reg;
   assign lnk.kind = kind_reg;
   assign lnk.last = last_reg;
   assign lnk.blk_start = blk_start_reg;
   assign lnk.blk_os = blk_os_reg;

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         state_reg <= ST_IDLE;
         cnt_reg <= '0;
         lc_cur_reg <= '0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         lc_cur_reg <= lc_cur_next;
      end
   end

   // Holds one command until the scheduler takes it.
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         lc_pend_reg <= 1'b0;
         lc_pend_code_reg <= '0;
         lc_ready_reg <= 1'b1;
      end else begin
         if (lc_valid_i && lc_ready_reg) begin
            lc_pend_reg <= 1'b1;
            lc_pend_code_reg <= lc_code_i;
         end else if (lc_take) begin
            lc_pend_reg <= 1'b0;
         end
         lc_ready_reg <= !((lc_valid_i && lc_ready_reg) || (lc_pend_reg && !lc_take));
      end
   end

   // A request in the cycle a skip starts wins and queues another.
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         skp_pend_reg <= 1'b0;
      end else if (skp_req_i) begin
         skp_pend_reg <= 1'b1;
      end else if (skp_take) begin
         skp_pend_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         pres_reg <= '0;
         presence_sent_o <= 1'b0;
      end else begin
         presence_sent_o <= pres_take;
         if (!u0_i || (e_kind != link_pkg::K_IDLE && e_kind != link_pkg::K_SKP)) begin
            pres_reg <= '0;
         end else if (pres_reg != PRES_LAST) begin
            pres_reg <= pres_reg + 9'h001;
         end
      end
   end

   // Tracks the symbol position inside an enhanced-rate block.
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         blk_reg <= '0;
         os_cur_reg <= 1'b0;
      end else begin
         os_cur_reg <= os_now;
         if (!enhanced_i || (blk_reg == 8'(BLK_LEN - 1))) begin
            blk_reg <= '0;
         end else begin
            blk_reg <= blk_reg + 8'h01;
         end
      end
   end

   // Reset shows a finished skip set, so the partner's scrambler stays aligned.
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         lfsr_reg <= link_pkg::SCR_SEED;
         sym_reg <= link_pkg::SKP_SYM;
         kind_reg <= link_pkg::K_SKP;
         last_reg <= 1'b1;
         blk_start_reg <= 1'b0;
         blk_os_reg <= 1'b0;
      end else begin
         if (e_kind != link_pkg::K_SKP) begin
            lfsr_reg <= link_pkg::scr_next(lfsr_reg);
         end
         if (e_kind == link_pkg::K_SKP || scr_bypass_i) begin
            sym_reg <= e_raw;
         end else begin
            sym_reg <= e_raw ^ link_pkg::scr_byte(lfsr_reg);
         end
         kind_reg <= e_kind;
         last_reg <= e_last;
         blk_start_reg <= enhanced_i && (blk_reg == '0);
         blk_os_reg <= os_now;
      end
   end
endmodule

// ### verification/link_command_placement_idle_asserts.sv
/* Placement checks on the symbol link between the two ports.
   Assumes the bench hands over the link signals, clk_i and resetn_i. */
`timescale 1ns/1ps
module link_command_placement_idle_asserts (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic [7:0] sym,
   input wire link_pkg::sym_kind_t kind,
   input wire logic last,
   input wire logic blk_start,
   input wire logic blk_os
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!resetn_i);
   property p_hp_whole;
      kind == link_pkg::K_HP && !last |=> kind != link_pkg::K_LC;
   endproperty
   a_hp_whole: assert property (p_hp_whole)
      else $error("command inside header packet");
   property p_dph_whole;
      kind == link_pkg::K_DPH && !last |=> kind == link_pkg::K_DPH;
   endproperty
   a_dph_whole: assert property (p_dph_whole)
      else $error("data header broken up");
   property p_dpp_whole;
      kind == link_pkg::K_DPP && !last |=> kind != link_pkg::K_LC;
   endproperty
   a_dpp_whole: assert property (p_dpp_whole)
      else $error("command inside payload");
   property p_dph_dpp;
      kind == link_pkg::K_DPH && last |=> kind == link_pkg::K_DPP;
   endproperty
   a_dph_dpp: assert property (p_dph_dpp)
      else $error("payload not right after data header");
   property p_skp_run;
      $rose(kind == link_pkg::K_SKP) |-> (kind == link_pkg::K_SKP) [*4];
   endproperty
   a_skp_run: assert property (p_skp_run)
      else $error("skip set cut short");
   property p_skp_first;
      kind == link_pkg::K_SKP && !last |=> kind == link_pkg::K_SKP;
   endproperty
   a_skp_first: assert property (p_skp_first)
      else $error("command inside skip set");
   property p_os_no_lc;
      blk_os |-> kind != link_pkg::K_LC;
   endproperty
   a_os_no_lc: assert property (p_os_no_lc)
      else $error("command in ordered set block");
   property p_lc_pair;
      kind == link_pkg::K_LC && !last |=> kind == link_pkg::K_LC && last;
   endproperty
   a_lc_pair: assert property (p_lc_pair)
      else $error("command not two symbols");
endmodule

// ### verification/link_command_placement_idle_tb_top.sv
/* Bench joining the transmit and receive ports over one link.
   Assumes the two ends as declared in core. */
`timescale 1ns/1ps
module link_command_placement_idle_tb_top;
   typedef struct {link_pkg::sym_kind_t k; int len; logic [7:0] b;} row_t;
   row_t rows[3] = '{'{link_pkg::K_HP, 4, 8'h20}, '{link_pkg::K_DPH, 4, 8'h30},
      '{link_pkg::K_DPP, 5, 8'h40}};
   logic [15:0] lcx[3] = '{16'h1234, 16'h5678, 16'h9abc};
   logic clk_i = 0, resetn_i = 0, dn = 1, enh = 0, byp = 1, pv = 0, plast = 0;
   logic lv = 0, skp = 0, u0 = 1, pr, lr, pres, rxv, lcv, perr;
   logic [7:0] pd = 8'h00, rxb, s;
   logic [15:0] lcc = 16'h0000, lco;
   link_pkg::sym_kind_t pk = link_pkg::K_IDLE, rxk;
   logic [7:0] eb[$], gb[$];
   logic [15:0] gl[$];
   int fail_count = 0, n_compared = 0, perr_n = 0, pres_n = 0, n;
   link_if lnk();
   link_tx_port u_link_tx_port (.clk_i(clk_i), .resetn_i(resetn_i), .lnk(lnk), .u0_i(u0),
      .downstream_i(dn), .enhanced_i(enh), .scr_bypass_i(byp), .pkt_valid_i(pv),
      .pkt_ready_o(pr), .pkt_data_i(pd), .pkt_kind_i(pk), .pkt_last_i(plast),
      .lc_valid_i(lv), .lc_ready_o(lr), .lc_code_i(lcc), .skp_req_i(skp),
      .presence_sent_o(pres));
   link_rx_port u_link_rx_port (.clk_i(clk_i), .resetn_i(resetn_i), .lnk(lnk),
      .scr_bypass_i(byp), .enhanced_i(enh), .rx_valid_o(rxv), .rx_byte_o(rxb),
      .rx_kind_o(rxk), .lc_valid_o(lcv), .lc_code_o(lco), .place_err_o(perr));
   link_command_placement_idle_asserts u_link_command_placement_idle_asserts (
      .clk_i(clk_i), .resetn_i(resetn_i), .sym(lnk.sym), .kind(lnk.kind),
      .last(lnk.last), .blk_start(lnk.blk_start), .blk_os(lnk.blk_os));
   initial forever #12.5 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      if (rxv === 1'b1) gb.push_back(rxb);
      if (lcv === 1'b1) gl.push_back(lco);
      if (perr === 1'b1) perr_n++;
      if (pres === 1'b1) pres_n++;
   end
   task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic finish_test();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic rst();
      resetn_i = 0;
      repeat (5) @(posedge clk_i);
      #1 resetn_i = 1;
   endtask
   task automatic put(link_pkg::sym_kind_t k, logic [7:0] d, logic l);
      int t;
      pk = k; pd = d; plast = l; pv = 1; t = 0;
      do begin @(posedge clk_i); t++; end while (pr !== 1'b1 && t < 200);
      #1;
   endtask
   task automatic lc(logic [15:0] c);
      int t;
      lcc = c; lv = 1; t = 0;
      do begin @(posedge clk_i); t++; end while (lr !== 1'b1 && t < 200);
      #1;
   endtask
   task automatic idle_sym(output logic [7:0] v);
      int t;
      t = 0;
      do begin @(posedge clk_i); t++; end while (lnk.kind !== link_pkg::K_IDLE && t < 50);
      v = lnk.sym;
      #1;
   endtask
   initial begin
      #(25 * 30000);
      fail_count++;
      finish_test();
   end
   initial begin
      rst();
      foreach (rows[r]) for (int j = 0; j < rows[r].len; j++) begin
         put(rows[r].k, rows[r].b + 8'(j), j == rows[r].len - 1);
         eb.push_back(rows[r].b + 8'(j));
      end
      pv = 0;
      repeat (20) @(posedge clk_i);
      chk("rx_count", 16'(eb.size()), 16'(gb.size()));
      foreach (eb[i]) chk("rx_byte", eb[i], gb[i]);
      for (int m = 0; m < 2; m++) begin
         #1 enh = m[0];
         rst();
         gl.delete();
         fork
            begin
               put(link_pkg::K_DPH, 8'h11, 0); put(link_pkg::K_DPH, 8'h12, 1);
               put(link_pkg::K_DPP, 8'h13, 0); put(link_pkg::K_DPP, 8'h14, 1); pv = 0;
            end
            begin @(posedge clk_i); #1 lc(lcx[0]); lc(lcx[1]); lv = 0; end
         join
         skp = 1;
         @(posedge clk_i);
         #1 skp = 0;
         lc(lcx[2]);
         lv = 0;
         repeat (60) @(posedge clk_i);
         foreach (lcx[i]) chk("lc_code", lcx[i], gl[i]);
         idle_sym(s);
         chk("idle_sym", m ? link_pkg::IDLE_ENH : link_pkg::IDLE_BASE, s);
      end
      byp = 0;
      rst();
      n = 0;
      repeat (16) begin idle_sym(s); if (s !== link_pkg::IDLE_ENH) n++; end
      chk("idle_scrambled", 16'h0001, 16'(n > 0));
      for (int d = 1; d >= 0; d--) begin
         dn = d[0];
         rst();
         lc(16'h0f0f);
         lv = 0;
         n = 0;
         while (pres !== 1'b1 && n < 1000) begin @(posedge clk_i); n++; end
         chk("pres_wait", 16'h0001, 16'(n >= link_pkg::PRES_CYCLES - 4 &&
            n <= link_pkg::PRES_CYCLES + 16));
         repeat (10) @(posedge clk_i);
         chk("pres_code", d ? link_pkg::LC_CODE_DN : link_pkg::LC_CODE_UP, gl[$]);
      end
      #1 u0 = 0;
      rst();
      pres_n = 0;
      repeat (450) @(posedge clk_i);
      chk("pres_off", 16'h0000, 16'(pres_n));
      #1 pk = link_pkg::K_HP;
      pv = 1;
      n = 0;
      while (n < 20) begin
         pd = 8'(n);
         plast = (n == link_pkg::FIFO_DEPTH - 1);
         @(posedge clk_i);
         if (pr !== 1'b1) break;
         n++;
         #1;
      end
      #1 pv = 0;
      chk("fifo_fill", 16'(link_pkg::FIFO_DEPTH), 16'(n));
      gb.delete();
      u0 = 1;
      repeat (20) @(posedge clk_i);
      chk("fifo_drain", 16'(link_pkg::FIFO_DEPTH), 16'(gb.size()));
      foreach (gb[i]) chk("fifo_data", 16'(i), 16'(gb[i]));
      chk("place_err", 16'h0000, 16'(perr_n));
      finish_test();
   end
endmodule
